// ### hdl/otpps_consts.svh
// Functional notes
// - program each word with nominal 100 us pulse
// - every pulse lasts 95 to 105 us
// - start at first address, step upward
// - first pass one pulse, no verify
// - then verify and reprogram each address
// - failed word gets up to 10 pulses
// - still failing after tenth pulse: part fails
// - verified word moves to next address
// - final read of all words, report result
// - wait 150 ns after output enable
// - address bit zero selects id word
`ifndef OTPPS_CONSTS_SVH
`define OTPPS_CONSTS_SVH
`define OTPPS_CLK_PERIOD_PS 5000
`define OTPPS_PULSE_NOM_NS 100000
`define OTPPS_PULSE_MIN_NS 95000
`define OTPPS_PULSE_MAX_NS 105000
`define OTPPS_VERIFY_WAIT_NS 150
`define OTPPS_SETUP_NS 2000
`define OTPPS_MAX_RETRY 10
`define OTPPS_ADDR_W 16
`define OTPPS_DATA_W 16
`define OTPPS_NS_TO_CYC(ns) (((ns) * 1000 + `OTPPS_CLK_PERIOD_PS - 1) / `OTPPS_CLK_PERIOD_PS)
`endif

// ### hdl/otpps_pkg.sv
package otpps_pkg;
   typedef enum logic [1:0] {
      OTPPS_OP_PROGRAM,
      OTPPS_OP_IDENT,
      OTPPS_OP_READ
   } otpps_op_t;
   // pins toward the memory, all flop driven
   typedef struct packed {
      logic [15:0] addr;
      logic chip_enable_n;
      logic output_enable_n;
      logic program_strobe_n;
      logic id_select_addr_line;
      logic [15:0] data_out;
      logic data_oe;
   } otpps_pins_t;
endpackage : otpps_pkg

// ### hdl/otpps_image_mem.sv
`timescale 1ns/1ps
`default_nettype none
// image of the words to burn, written by the user side
module otpps_image_mem #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input wire logic clk_sys_i, // system clock
   input wire logic wr_en_i, // write strobe
   input wire logic [ADDR_W-1:0] wr_addr_i, // write address
   input wire logic [DATA_W-1:0] wr_data_i, // write data
   input wire logic [ADDR_W-1:0] rd_addr_i, // read address
   output logic [DATA_W-1:0] rd_data_o // registered read data
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   // no reset: block ram contents are undefined until loaded
   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule : otpps_image_mem
`default_nettype wire

// ### hdl/otpps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "otpps_consts.svh"
module otpps_sequencer #(
   parameter int ADDR_W = `OTPPS_ADDR_W,
   parameter int DATA_W = `OTPPS_DATA_W,
   parameter int PULSE_CYC = `OTPPS_NS_TO_CYC(`OTPPS_PULSE_NOM_NS),
   parameter int SETUP_CYC = `OTPPS_NS_TO_CYC(`OTPPS_SETUP_NS),
   parameter int MAX_RETRY = `OTPPS_MAX_RETRY,
   parameter logic [ADDR_W-1:0] LAST_ADDR = 16'hFFFF
) (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_i, // async reset, high
   input wire logic img_wr_i, // image write strobe
   input wire logic [ADDR_W-1:0] img_addr_i, // image write address
   input wire logic [DATA_W-1:0] img_data_i, // image write data
   input wire logic start_i, // start pulse
   input wire otpps_pkg::otpps_op_t op_i, // operation at start
   input wire logic id_sel_i, // 0 maker word, 1 device word
   input wire logic [DATA_W-1:0] data_lines_i, // memory data pins
   output otpps_pkg::otpps_pins_t pins_o, // memory control pins
   output logic busy_o, // sequence running
   output logic done_o, // one-cycle end pulse
   output logic pass_o, // result of last run
   output logic [DATA_W-1:0] id_word_o, // identification word read
   output logic [ADDR_W-1:0] fail_addr_o // address of failure
);
   localparam int VWAIT_CYC = `OTPPS_NS_TO_CYC(`OTPPS_VERIFY_WAIT_NS);
   localparam int CNT_W = $clog2(PULSE_CYC + SETUP_CYC + VWAIT_CYC + 2);
   typedef enum {
      S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_VOE, S_VCMP, S_DONE
   } otpps_state_t;
   typedef enum logic [1:0] {P_FIRST, P_LOOP, P_FINAL, P_IDENT} otpps_pass_t;

   otpps_state_t state;
   otpps_pass_t pass_kind;
   logic [CNT_W-1:0] cnt;
   logic [ADDR_W-1:0] addr;
   logic [3:0] retry;
   logic fail;
   logic [DATA_W-1:0] img_q;
   logic match;
   logic again; // a retry pulse is pending behind a fresh setup

   function automatic logic [CNT_W-1:0] to_cnt(input int v);
      to_cnt = CNT_W'(v);
   endfunction : to_cnt

   otpps_image_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mem (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(img_wr_i),
      .wr_addr_i(img_addr_i),
      .wr_data_i(img_data_i),
      .rd_addr_i(addr),
      .rd_data_o(img_q)
   );

   assign match = (data_lines_i == img_q);
   assign busy_o = (state != S_IDLE);

   //////////////////////////////////////////////////////////////////////
   // main sequence
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         pass_kind <= P_FIRST;
         cnt <= '0;
         addr <= '0;
         retry <= 4'h0;
         fail <= 1'b0;
         again <= 1'b0;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (start_i) begin
                  addr <= '0;
                  retry <= 4'h0;
                  fail <= 1'b0;
                  again <= 1'b0;
                  cnt <= to_cnt(SETUP_CYC);
                  state <= S_SETUP;
                  unique case (op_i)
                     otpps_pkg::OTPPS_OP_PROGRAM: pass_kind <= P_FIRST;
                     otpps_pkg::OTPPS_OP_IDENT: pass_kind <= P_IDENT;
                     default: pass_kind <= P_FINAL;
                  endcase
               end
            end
            // data and address settle before strobe or output enable
            S_SETUP: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else if (pass_kind == P_FIRST || again) begin
                  again <= 1'b0;
                  cnt <= to_cnt(PULSE_CYC - 1);
                  state <= S_PULSE;
               end else begin
                  cnt <= to_cnt(VWAIT_CYC - 1);
                  state <= S_VOE;
               end
            end
            S_PULSE: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  cnt <= to_cnt(SETUP_CYC);
                  state <= S_HOLD;
               end
            end
            // data hold after the strobe rises
            S_HOLD: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else if (pass_kind == P_FIRST) begin
                  // no verify in the first pass
                  if (addr == LAST_ADDR) begin
                     addr <= '0;
                     pass_kind <= P_LOOP;
                  end else begin
                     addr <= addr + 1'b1;
                  end
                  cnt <= to_cnt(SETUP_CYC);
                  state <= S_SETUP;
               end else begin
                  cnt <= to_cnt(VWAIT_CYC - 1);
                  state <= S_VOE;
               end
            end
            S_VOE: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  state <= S_VCMP;
               end
            end
            S_VCMP: begin
               cnt <= to_cnt(SETUP_CYC);
               if (pass_kind == P_IDENT) begin
                  state <= S_DONE;
               end else if (pass_kind == P_FINAL) begin
                  if (!match) begin
                     fail <= 1'b1;
                  end
                  if (addr == LAST_ADDR) begin
                     state <= S_DONE;
                  end else begin
                     addr <= addr + 1'b1;
                     state <= S_SETUP;
                  end
               end else if (match) begin
                  retry <= 4'h0;
                  if (addr == LAST_ADDR) begin
                     addr <= '0;
                     pass_kind <= P_FINAL;
                  end else begin
                     addr <= addr + 1'b1;
                  end
                  state <= S_SETUP;
               end else if (retry == 4'(MAX_RETRY)) begin
                  fail <= 1'b1;
                  state <= S_DONE;
               end else begin
                  // back through setup so oe is high well before the strobe
                  retry <= retry + 1'b1;
                  again <= 1'b1;
                  state <= S_SETUP;
               end
            end
            S_DONE: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // pin drive: write keeps oe high, verify keeps strobe high
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pins_o <= '{addr: '0, chip_enable_n: 1'b1, output_enable_n: 1'b1,
                     program_strobe_n: 1'b1, id_select_addr_line: 1'b0,
                     data_out: '0, data_oe: 1'b0};
      end else begin
         // address bit zero alone picks the id word
         pins_o.addr <= (pass_kind == P_IDENT) ?
                        {{(ADDR_W-1){1'b0}}, id_sel_i} : addr;
         pins_o.id_select_addr_line <= busy_o && (pass_kind == P_IDENT);
         pins_o.chip_enable_n <= !busy_o || (state == S_DONE);
         pins_o.program_strobe_n <= !(state == S_PULSE);
         pins_o.output_enable_n <= !((state == S_VOE) || (state == S_VCMP));
         pins_o.data_oe <= (state == S_SETUP &&
                            (pass_kind == P_FIRST || again)) ||
                           state == S_PULSE || state == S_HOLD;
         pins_o.data_out <= img_q;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // results; id upper byte forced to zero as the part drives it
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
         pass_o <= 1'b0;
         id_word_o <= '0;
         fail_addr_o <= '0;
      end else begin
         done_o <= (state == S_DONE);
         if (state == S_DONE) begin
            pass_o <= !fail && (pass_kind != P_IDENT);
         end
         // latest miscompare before fail is set; retried words land here too, so
         // the value only means something while pass is low
         if (state == S_VCMP && !match && !fail && pass_kind != P_IDENT) begin
            fail_addr_o <= addr;
         end
         if (state == S_VCMP && pass_kind == P_IDENT) begin
            id_word_o <= {8'h00, data_lines_i[7:0]};
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // checks
   // window scales with the pulse count, so a shortened pulse keeps +-5%
   localparam int PW_MIN = int'(longint'(PULSE_CYC) *
                                `OTPPS_PULSE_MIN_NS / `OTPPS_PULSE_NOM_NS);
   localparam int PW_MAX = int'(longint'(PULSE_CYC) *
                                `OTPPS_PULSE_MAX_NS / `OTPPS_PULSE_NOM_NS);
   int pw_cnt;
   int oe_low_cnt;
   // cycles the output enable has stood low, for the sample check
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         oe_low_cnt <= 0;
      end else begin
         oe_low_cnt <= pins_o.output_enable_n ? 0 : oe_low_cnt + 1;
      end
   end
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pw_cnt <= 0;
      end else begin
         pw_cnt <= pins_o.program_strobe_n ? 0 : pw_cnt + 1;
      end
   end
   chk_pulse_width: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(pins_o.program_strobe_n) |-> ($past(pw_cnt) + 1 >= PW_MIN
      && $past(pw_cnt) + 1 <= PW_MAX))
      else $error("program pulse width out of range");
   chk_pulse_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      pw_cnt <= PW_MAX)
      else $error("program pulse too long");
   chk_oe_strobe_excl: assert property (@(posedge clk_sys_i)
      disable iff (rst_i)
      !(!pins_o.output_enable_n && !pins_o.program_strobe_n))
      else $error("oe and strobe low together");
   // pin went low one edge before the count starts, hence the plus one
   chk_verify_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      state == S_VCMP |-> !pins_o.output_enable_n
      && oe_low_cnt + 1 >= VWAIT_CYC)
      else $error("sampled too soon after oe");
   chk_start_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_IDLE && start_i) |=> addr == '0)
      else $error("sequence did not start at address zero");
   chk_retry_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      retry <= 4'(MAX_RETRY))
      else $error("too many extra pulses");
   chk_fail_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == S_VCMP && pass_kind == P_LOOP && !match
       && retry == 4'(MAX_RETRY)) |=> state == S_DONE ##1 done_o)
      else $error("failed word did not stop the run");
   chk_first_noverify: assert property (@(posedge clk_sys_i)
      disable iff (rst_i)
      (pass_kind == P_FIRST) |-> pins_o.output_enable_n || $changed(pass_kind))
      else $error("verify during first pass");
   chk_id_upper: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      id_word_o[15:8] == 8'h00)
      else $error("id upper byte not zero");
   cov_program_done: cover property (@(posedge clk_sys_i)
      done_o && pass_o);
   cov_retry: cover property (@(posedge clk_sys_i)
      state == S_VCMP && !match && pass_kind == P_LOOP);
   cov_ident: cover property (@(posedge clk_sys_i)
      state == S_VCMP && pass_kind == P_IDENT);
endmodule : otpps_sequencer
`default_nettype wire

// ### tb/otpps_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural one-time memory seen from the controller pins
module otpps_mem_model #(
   parameter int PW_MIN = 19, // shortest legal pulse, cycles
   parameter int PW_MAX = 21, // longest legal pulse, cycles
   parameter int VW = 30, // cycles from oe low to valid data
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] DEVICE_ID = 8'hC3 // arbitrary value
) (
   input wire logic clk_sys_i, // system clock
   input wire logic clear_i, // fit a fresh blank part
   input wire otpps_pkg::otpps_pins_t pins_i, // control pins
   input wire logic [15:0] bus_i, // resolved data lines
   output logic [15:0] data_o, // level the part puts on the lines
   output logic [3:0] err_o // mode, order, width, id address
);
   logic [15:0] arr [16];
   int need [16];
   int pcnt [16];
   int wcnt;
   int ocnt;
   logic [15:0] prev_a;
   logic [15:0] last;
   logic [15:0] pdata;
   logic [15:0] word;
   logic strobe_q;
   logic out_en;
   logic [3:0] a;
   ////////////////////////////////////////////////////////////////////////
   // drive only when selected, enabled and not programming
   assign out_en = !pins_i.chip_enable_n && !pins_i.output_enable_n &&
      pins_i.program_strobe_n;
   assign a = pins_i.addr[3:0];
   // id mode: address bit zero picks the word, upper byte zero
   always_comb begin
      if (pins_i.id_select_addr_line) begin
         word = {8'h00, pins_i.addr[0] ? DEVICE_ID : MAKER_ID};
      end else begin
         word = arr[a];
      end
   end
   // early or floating lines toggle so a stale value never passes
   assign data_o = (ocnt >= VW - 1) ? word : ~last;
   ////////////////////////////////////////////////////////////////////////
   // programming, timing and protocol watch
   always @(posedge clk_sys_i) begin
      last <= data_o;
      strobe_q <= pins_i.program_strobe_n;
      ocnt <= out_en ? ocnt + 1 : 0;
      if (pins_i.id_select_addr_line && out_en && pins_i.addr[15:1] != 0) begin
         err_o[3] <= 1'b1;
      end
      // reads may restart at zero for a new pass, else never step back
      if (out_en && !pins_i.id_select_addr_line) begin
         if (pins_i.addr < prev_a && pins_i.addr != 16'h0000) begin
            err_o[1] <= 1'b1;
         end
         prev_a <= pins_i.addr;
      end
      if (!pins_i.program_strobe_n) begin
         wcnt <= wcnt + 1;
         pdata <= bus_i;
         if (pins_i.chip_enable_n || !pins_i.output_enable_n) begin
            err_o[0] <= 1'b1;
         end
      end
      if (pins_i.program_strobe_n && !strobe_q) begin
         if (wcnt < PW_MIN || wcnt > PW_MAX) err_o[2] <= 1'b1;
         if (pins_i.addr < prev_a) err_o[1] <= 1'b1;
         prev_a <= pins_i.addr;
         pcnt[a] <= pcnt[a] + 1;
         // a slow cell takes only after its count of pulses
         if (pcnt[a] + 1 >= need[a]) arr[a] <= arr[a] & pdata;
         wcnt <= 0;
      end
      if (clear_i) begin
         err_o <= 4'h0;
         prev_a <= 16'h0000;
         wcnt <= 0;
         for (int i = 0; i < 16; i++) begin
            arr[i] <= 16'hFFFF;
            pcnt[i] <= 0;
         end
      end
   end
endmodule : otpps_mem_model
`default_nettype wire

// ### tb/otp_rom_program_verify_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module otp_rom_program_verify_sequencer_tb;
   localparam int PULSE = 20;
   localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
   localparam logic [7:0] DEVICE = 8'hC3; // arbitrary value
   logic clk_sys_i, rst_i, img_wr_i, start_i, id_sel_i, clear;
   logic busy, done, pass;
   logic [15:0] img_addr_i, img_data_i, lines, mdata, fail_addr, id_word;
   logic [3:0] merr;
   otpps_pkg::otpps_op_t op;
   otpps_pkg::otpps_pins_t pins;
   int mismatches, n_tests;
   logic [15:0] img [4] = '{16'hA5C3, 16'h0000, 16'h1234, 16'h7E81};
   ////////////////////////////////////////////////////////////////////////
   // controller wins the lines while it drives them
   assign lines = pins.data_oe ? pins.data_out : mdata;
   otpps_sequencer #(.PULSE_CYC(PULSE), .SETUP_CYC(2),
      .LAST_ADDR(16'h0003)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .img_wr_i(img_wr_i), .img_addr_i(img_addr_i), .img_data_i(img_data_i),
      .start_i(start_i), .op_i(op), .id_sel_i(id_sel_i),
      .data_lines_i(lines), .pins_o(pins), .busy_o(busy), .done_o(done),
      .pass_o(pass), .id_word_o(id_word), .fail_addr_o(fail_addr));
   otpps_mem_model #(.PW_MIN(PULSE * 95 / 100), .PW_MAX(PULSE * 105 / 100),
      .MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) model (.clk_sys_i(clk_sys_i),
      .clear_i(clear), .pins_i(pins), .bus_i(lines), .data_o(mdata),
      .err_o(merr));
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic tick;
      @(posedge clk_sys_i);
      #1;
   endtask : tick
   // new blank part, slow cell at address sa, image loaded
   task automatic fresh(input int sa, input int n);
      clear = 1'b1;
      tick();
      clear = 1'b0;
      for (int i = 0; i < 16; i++) model.need[i] = (i == sa) ? n : 1;
      for (int i = 0; i < 4; i++) begin
         img_wr_i = 1'b1;
         img_addr_i = 16'(i);
         img_data_i = img[i];
         tick();
      end
      img_wr_i = 1'b0;
   endtask : fresh
   // start pulse, optional second start while busy, bounded wait
   task automatic run(input otpps_pkg::otpps_op_t o, input bit poke);
      op = o;
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
      if (poke) begin
         repeat (5) tick();
         op = otpps_pkg::OTPPS_OP_PROGRAM;
         start_i = 1'b1;
         tick();
         start_i = 1'b0;
      end
      for (int k = 0; k < 20000 && done !== 1'b1; k++) tick();
      chk("done", 16'h0001, {15'h0, done});
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   task automatic t_prog_ok;
      fresh(0, 1);
      run(otpps_pkg::OTPPS_OP_PROGRAM, 1'b0);
      chk("pass", 16'h0001, {15'h0, pass});
      for (int i = 0; i < 4; i++) begin
         chk("word", img[i], model.arr[i]);
         chk("pulses", 16'h0001, 16'(model.pcnt[i]));
      end
      chk("model err", 16'h0000, {12'h0, merr});
   endtask : t_prog_ok
   task automatic t_retry;
      fresh(3, 11);
      model.need[2] = 4;
      run(otpps_pkg::OTPPS_OP_PROGRAM, 1'b0);
      chk("pass", 16'h0001, {15'h0, pass});
      chk("pulses two", 16'h0004, 16'(model.pcnt[2]));
      chk("pulses three", 16'h000B, 16'(model.pcnt[3]));
      chk("word three", img[3], model.arr[3]);
      chk("model err", 16'h0000, {12'h0, merr});
   endtask : t_retry
   task automatic t_fail;
      fresh(1, 12);
      run(otpps_pkg::OTPPS_OP_PROGRAM, 1'b0);
      chk("pass", 16'h0000, {15'h0, pass});
      chk("fail addr", 16'h0001, fail_addr);
      chk("pulses one", 16'h000B, 16'(model.pcnt[1]));
      chk("pulses two", 16'h0001, 16'(model.pcnt[2]));
   endtask : t_fail
   task automatic t_final;
      fresh(0, 1);
      run(otpps_pkg::OTPPS_OP_PROGRAM, 1'b0);
      run(otpps_pkg::OTPPS_OP_READ, 1'b0);
      chk("read pass", 16'h0001, {15'h0, pass});
      model.arr[2] = img[2] ^ 16'h0100;
      run(otpps_pkg::OTPPS_OP_READ, 1'b0);
      chk("read fail", 16'h0000, {15'h0, pass});
      chk("read fail addr", 16'h0002, fail_addr);
   endtask : t_final
   task automatic t_ident;
      for (int s = 0; s < 2; s++) begin
         id_sel_i = s[0];
         run(otpps_pkg::OTPPS_OP_IDENT, 1'b0);
         chk("id", {8'h00, s ? DEVICE : MAKER}, id_word);
         chk("id pass", 16'h0000, {15'h0, pass});
      end
      chk("model err", 16'h0000, {12'h0, merr});
   endtask : t_ident
   // a start during a run must be ignored: no pulse follows
   task automatic t_refuse;
      fresh(0, 1);
      run(otpps_pkg::OTPPS_OP_IDENT, 1'b1);
      repeat (2) tick();
      chk("busy", 16'h0000, {15'h0, busy});
      chk("pulses", 16'h0000, 16'(model.pcnt[0]));
   endtask : t_refuse
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      clear = 1'b1;
      img_wr_i = 1'b0;
      start_i = 1'b0;
      id_sel_i = 1'b0;
      img_addr_i = 16'h0000;
      img_data_i = 16'h0000;
      op = otpps_pkg::OTPPS_OP_PROGRAM;
      repeat (12) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      clear = 1'b0;
      t_prog_ok();
      t_retry();
      t_fail();
      t_final();
      t_ident();
      t_refuse();
      finish_test();
   end
   // the whole test takes about 3000 cycles, the longest run about 1100; this bound cuts a hang
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      mismatches++;
      $display("[ERR] watchdog expected done seen hang");
      finish_test();
   end
endmodule : otp_rom_program_verify_sequencer_tb
`default_nettype wire
